// ==== lic_consts.svh ====
/*
  constants of the multilevel interrupt controller: register indices,
  field positions, reset values, write masks and small counts.
  assumes inclusion by its bare name; definitions only.
*/
`ifndef LIC_CONSTS_SVH
`define LIC_CONSTS_SVH

// number of maskable sources, and width of a source index
`define N_SRC          16
`define SRC_IDX_W      4

// register indices; byte address is four times the index
`define IDX_EXEC       3'h0
`define IDX_PTR        3'h1
`define IDX_CTRL       3'h2
`define IDX_EVT        3'h3
`define IDX_MASK       3'h4
`define IDX_UNLOCK     3'h5

// executing-flags register fields
`define BIT_NMI_EX     7
`define BIT_HI_EX      2
`define BIT_MED_EX     1
`define BIT_LO_EX      0

// control register fields
`define BIT_RR         7
`define BIT_VTS        6
`define BIT_HI_EN      2
`define BIT_MED_EN     1
`define BIT_LO_EN      0
`define CTRL_WMASK     8'h87
`define CTRL_VTS_MASK  8'h40

// reset values
`define CTRL_RST       8'h00
`define PTR_RST        8'h00
`define EVT_RST        4'h0
`define MASK_RST       4'h0

// event bits: acknowledge, return, return with nothing running, nmi
`define EVT_W          4
`define EVT_ACK        0
`define EVT_RET        1
`define EVT_BADRET     2
`define EVT_NMI        3

// protected-change unlock: key value and open window in cycles
`define UNLOCK_KEY     8'hD8
`define UNLOCK_CYCLES  3'h4

// vector number reported for the non-maskable request
`define NMI_VECTOR     8'hFF

`endif

// ==== lic_pkg.sv ====
/*
  types shared by the multilevel interrupt controller and its users.
  assumes lic_consts.svh is not needed here; types only.
*/
package lic_pkg;

  // two-bit level code carried by every request
  typedef enum logic [1:0] {
    LVL_OFF = 2'b00,
    LVL_LO  = 2'b01,
    LVL_MED = 2'b10,
    LVL_HI  = 2'b11
  } level_t;

  // one flag per level that has a handler running or pre-empted
  typedef struct packed {
    logic nmi;
    logic hi;
    logic med;
    logic lo;
  } exec_flags_t;

  // request presented to the core
  typedef struct packed {
    logic       valid;
    logic       is_nmi;
    level_t     level;
    logic [7:0] vector;
  } core_req_t;

endpackage

// ==== level_interrupt_controller.sv ====
/*
  multilevel interrupt controller: level gating, nesting flags, static
  and rotating priority, vector table select behind an unlock window,
  avalon-mm register slave with a sticky event interrupt.
  assumes sources and core run on CLK; sources hold a request until
  serviced; the core pulses CORE_ACK and CORE_RETURN for one cycle.
*/
`timescale 1ns/100ps
`include "lic_consts.svh"

//Contract
//- low flag set while running, cleared on return
//- rotating mode records acknowledged low vector
//- recorded vector is lowest low priority
//- software reads/writes pointer, effective immediately
//- pointer kept when rotation turned off
//- rotation bit affects low level only
//- static order: lowest vector wins
//- select bit chooses application or boot table
//- select bit writable only after unlock
//- control bits 5..3 read zero
//- high enable gates high requests
//- medium enable gates medium requests
//- low enable gates low requests
//- cleared enable ignores one cycle later
//- level codes: off, low, medium, high
//- higher level pre-empts, lower resumes after
//- high, medium, nmi always static
//- nmi flag set running, cleared on return
module level_interrupt_controller import lic_pkg::*; (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic [4:0]            AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  output logic      [31:0]           AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic [`N_SRC-1:0]     SRC_PEND,
  input  wire logic [2*`N_SRC-1:0]   SRC_LEVEL,
  input  wire logic                  NMI_PEND,
  output core_req_t                  CORE_REQ,
  input  wire logic                  CORE_ACK,
  input  wire logic                  CORE_RETURN,
  output logic                       VECTOR_TABLE_SEL,
  output logic                       IRQ
);

  // registered state
  logic [7:0]            ctrl_q, ctrl_d;     // control register
  logic [7:0]            ptr_q, ptr_d;       // round robin pointer
  exec_flags_t           ex_q, ex_d;         // executing flags
  logic [`EVT_W-1:0]     evt_q, evt_d;       // sticky events
  logic [`EVT_W-1:0]     mask_q, mask_d;     // event mask
  logic [2:0]            unlock_q, unlock_d; // unlock window left
  logic                  ack_q, ack_d;       // bus answer phase
  logic [7:0]            rdata_q, rdata_d;   // read data holding
  core_req_t             req_q, req_d;       // request to core
  logic                  irq_q, irq_d;       // interrupt line

  // combinational helpers
  logic                  bus_req;            // read or write pending
  logic                  bus_done;           // answer edge
  logic [2:0]            idx;                // register index
  logic                  aligned;            // low address bits zero
  logic                  wr_en;              // low lane write taken
  logic                  ptr_wr;             // pointer written now
  logic                  ctrl_wr;            // control written now
  logic                  evt_rd;             // event register read now
  logic                  take;               // core took request
  logic                  rr_on;              // rotation selected
  logic [`N_SRC-1:0]     hi_vec;             // eligible high sources
  logic [`N_SRC-1:0]     med_vec;            // eligible medium sources
  logic [`N_SRC-1:0]     lo_vec;             // eligible low sources
  logic [`N_SRC-1:0]     lo_rot;             // low sources, rotated
  logic [2*`N_SRC-1:0]   lo_dbl;             // doubled for rotation
  logic [`SRC_IDX_W-1:0] rot_start;          // first index searched
  logic [`SRC_IDX_W:0]   hi_pick;            // {found, index}
  logic [`SRC_IDX_W:0]   med_pick;
  logic [`SRC_IDX_W:0]   lo_pick;
  logic [`SRC_IDX_W-1:0] lo_idx;             // low winner, unrotated
  core_req_t             win;                // arbitration result
  logic [`EVT_W-1:0]     evt_set;            // events this cycle
  logic                  ret_bad;            // return with none running
  exec_flags_t           ex_ret;             // flags after return

  // first set bit from index zero upward; lowest index wins
  function automatic logic [`SRC_IDX_W:0] pick(
    input logic [`N_SRC-1:0] v
  );
    logic [`SRC_IDX_W:0] r;
    r = '0;
    for (int i = `N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, `SRC_IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // bus decode; one wait cycle on every access
  always_comb begin
    bus_req         = AVS_READ | AVS_WRITE;
    bus_done        = bus_req & ack_q & CE;
    AVS_WAITREQUEST = bus_req & ~(ack_q & CE);
    idx             = AVS_ADDRESS[4:2];
    aligned         = (AVS_ADDRESS[1:0] == 2'h0);
    wr_en           = bus_done & AVS_WRITE & aligned & AVS_BYTEENABLE[0];
    ptr_wr          = wr_en & (idx == `IDX_PTR);
    ctrl_wr         = wr_en & (idx == `IDX_CTRL);
    evt_rd          = bus_done & AVS_READ & aligned & (idx == `IDX_EVT);
    take            = CORE_ACK & req_q.valid;
    rr_on           = ctrl_q[`BIT_RR];
  end

  // per-source level decode and enable gating
  genvar g;
  for (g = 0; g < `N_SRC; g++) begin : g_src
    assign hi_vec[g]  = SRC_PEND[g] & ctrl_q[`BIT_HI_EN] &
                        (level_t'(SRC_LEVEL[2*g +: 2]) == LVL_HI);
    assign med_vec[g] = SRC_PEND[g] & ctrl_q[`BIT_MED_EN] &
                        (level_t'(SRC_LEVEL[2*g +: 2]) == LVL_MED);
    assign lo_vec[g]  = SRC_PEND[g] & ctrl_q[`BIT_LO_EN] &
                        (level_t'(SRC_LEVEL[2*g +: 2]) == LVL_LO);
  end

  // arbitration; the enables are read from ctrl_q, so a clear lands
  // one cycle after the write edge
  always_comb begin
    // static order for high and medium
    hi_pick   = pick(hi_vec);
    med_pick  = pick(med_vec);
    // start just after the recorded vector when rotating, else at index 0
    rot_start = rr_on ? (ptr_q[`SRC_IDX_W-1:0] + `SRC_IDX_W'(1))
                      : '0;
    lo_dbl    = {lo_vec, lo_vec} >> rot_start;
    lo_rot    = lo_dbl[`N_SRC-1:0];
    lo_pick   = pick(lo_rot);
    lo_idx    = lo_pick[`SRC_IDX_W-1:0] + rot_start;
    win       = '0;
    // only a strictly higher level pre-empts
    if (NMI_PEND && !ex_q.nmi) begin
      win.valid  = 1'b1;
      win.is_nmi = 1'b1;
      win.level  = LVL_HI;
      win.vector = `NMI_VECTOR;
    end else if (!ex_q.nmi) begin
      if (hi_pick[`SRC_IDX_W] && !ex_q.hi) begin
        win.valid  = 1'b1;
        win.level  = LVL_HI;
        win.vector = 8'(hi_pick[`SRC_IDX_W-1:0]);
      end else if (med_pick[`SRC_IDX_W] && !ex_q.hi && !ex_q.med) begin
        win.valid  = 1'b1;
        win.level  = LVL_MED;
        win.vector = 8'(med_pick[`SRC_IDX_W-1:0]);
      end else if (lo_pick[`SRC_IDX_W] && !ex_q.hi && !ex_q.med &&
                   !ex_q.lo) begin
        win.valid  = 1'b1;
        win.level  = LVL_LO;
        win.vector = 8'(lo_idx);
      end
    end
    // strobe dropped for the cycle after a take
    req_d = win;
    if (take) begin
      req_d.valid = 1'b0;
    end
  end

  // executing flags: a return clears the innermost level, then a take
  // sets the level it accepted
  always_comb begin
    ex_ret  = ex_q;
    ret_bad = 1'b0;
    if (CORE_RETURN) begin
      if (ex_q.nmi) begin
        ex_ret.nmi = 1'b0;
      end else if (ex_q.hi) begin
        ex_ret.hi = 1'b0;
      end else if (ex_q.med) begin
        ex_ret.med = 1'b0;
      end else if (ex_q.lo) begin
        ex_ret.lo = 1'b0;
      end else begin
        ret_bad = 1'b1;
      end
    end
    ex_d = ex_ret;
    if (take) begin
      if (req_q.is_nmi) begin
        ex_d.nmi = 1'b1;
      end else begin
        case (req_q.level)
          LVL_HI:  ex_d.hi  = 1'b1;
          LVL_MED: ex_d.med = 1'b1;
          LVL_LO:  ex_d.lo  = 1'b1;
          default: ex_d.lo  = ex_ret.lo;
        endcase
      end
    end
  end

  // software registers and the unlock window
  always_comb begin
    // software write takes effect at once
    ptr_d = ptr_wr ? AVS_WRITEDATA[7:0] : ptr_q;
    // no capture and no reset when rotation off
    if (take && rr_on && !req_q.is_nmi && req_q.level == LVL_LO) begin
      ptr_d = req_q.vector;
    end
    unlock_d = (unlock_q != 3'h0) ? unlock_q - 3'h1 : 3'h0;
    if (wr_en && idx == `IDX_UNLOCK &&
        AVS_WRITEDATA[7:0] == `UNLOCK_KEY) begin
      unlock_d = `UNLOCK_CYCLES;
    end
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = (ctrl_q & ~`CTRL_WMASK) | (AVS_WRITEDATA[7:0] & `CTRL_WMASK);
      if (unlock_q != 3'h0) begin
        ctrl_d = (ctrl_d & ~`CTRL_VTS_MASK) |
                 (AVS_WRITEDATA[7:0] & `CTRL_VTS_MASK);
      end
    end
    mask_d = (wr_en && idx == `IDX_MASK) ? AVS_WRITEDATA[`EVT_W-1:0]
                                         : mask_q;
  end

  // events: a read clears only the bits it reported; a set wins
  always_comb begin
    evt_set              = '0;
    evt_set[`EVT_ACK]    = take;
    evt_set[`EVT_RET]    = CORE_RETURN & ~ret_bad;
    evt_set[`EVT_BADRET] = ret_bad;
    evt_set[`EVT_NMI]    = take & req_q.is_nmi;
    evt_d = evt_q;
    if (evt_rd) begin
      evt_d = evt_q & ~rdata_q[`EVT_W-1:0];
    end
    evt_d = evt_d | evt_set;
    irq_d = |(evt_d & mask_d);
  end

  // read mux sampled in the wait cycle, presented in the answer cycle
  always_comb begin
    ack_d   = bus_req & ~ack_q;
    rdata_d = rdata_q;
    if (bus_req && !ack_q) begin
      rdata_d = 8'h00;
      if (aligned) begin
        case (idx)
          `IDX_EXEC:   rdata_d = {ex_q.nmi, 4'h0, ex_q.hi, ex_q.med,
                                  ex_q.lo};
          `IDX_PTR:    rdata_d = ptr_q;
          `IDX_CTRL:   rdata_d = ctrl_q & (`CTRL_WMASK | `CTRL_VTS_MASK);
          `IDX_EVT:    rdata_d = {4'h0, evt_q};
          `IDX_MASK:   rdata_d = {4'h0, mask_q};
          `IDX_UNLOCK: rdata_d = {5'h00, unlock_q};
          default:     rdata_d = 8'h00;
        endcase
      end
    end
  end

  // all state; CE low freezes every flip-flop
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q   <= `CTRL_RST;
      ptr_q    <= `PTR_RST;
      ex_q     <= '0;
      evt_q    <= `EVT_RST;
      mask_q   <= `MASK_RST;
      unlock_q <= 3'h0;
      ack_q    <= 1'b0;
      rdata_q  <= 8'h00;
      req_q    <= '0;
      irq_q    <= 1'b0;
    end else if (CE) begin
      ctrl_q   <= ctrl_d;
      ptr_q    <= ptr_d;
      ex_q     <= ex_d;
      evt_q    <= evt_d;
      mask_q   <= mask_d;
      unlock_q <= unlock_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      req_q    <= req_d;
      irq_q    <= irq_d;
    end
  end

  // outputs other than AVS_WAITREQUEST straight from flip-flops
  // table select driven to the core
  assign VECTOR_TABLE_SEL = ctrl_q[`BIT_VTS];
  assign CORE_REQ         = req_q;
  assign IRQ              = irq_q;
  assign AVS_READDATA     = {24'h000000, rdata_q};

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_lo_take;
    CE && take && !req_q.is_nmi && req_q.level == LVL_LO;
  endsequence

  sequence s_lo_off;
    ctrl_wr && !AVS_WRITEDATA[`BIT_LO_EN];
  endsequence

  a_lo_exec_set: assert property (s_lo_take |=> ex_q.lo)
    else $error("low flag not set after low take");
  a_rr_capture: assert property ((s_lo_take and rr_on) |=>
    ptr_q == $past(req_q.vector))
    else $error("pointer missed acknowledged low vector");
  a_rr_lowest: assert property (win.valid && win.level == LVL_LO &&
    rr_on && $countones(lo_vec) > 1 |->
    lo_idx != ptr_q[`SRC_IDX_W-1:0])
    else $error("recorded vector won with others pending");
  a_ptr_write: assert property (CE && ptr_wr && !take |=>
    ptr_q == $past(AVS_WRITEDATA[7:0]))
    else $error("pointer write not applied");
  a_ptr_kept: assert property (!rr_on && !ptr_wr |=>
    $stable(ptr_q))
    else $error("pointer changed with rotation off");
  // winner must be pending with no lower index pending beside it
  a_static_low: assert property (win.valid && win.level == LVL_LO &&
    !rr_on |-> lo_vec[lo_idx] &&
    ((lo_vec & ((`N_SRC'(1) << lo_idx) - `N_SRC'(1))) == '0))
    else $error("static low order broken");
  a_vts_locked: assert property (ctrl_wr && unlock_q == 3'h0 |=>
    $stable(VECTOR_TABLE_SEL))
    else $error("select changed without unlock");
  a_resv_zero: assert property (ctrl_q[5:3] == 3'h0)
    else $error("reserved control bits set");
  a_hi_gate: assert property (CE && !ctrl_q[`BIT_HI_EN] |=>
    !(req_q.valid && !req_q.is_nmi && req_q.level == LVL_HI))
    else $error("high request passed while disabled");
  a_med_gate: assert property (CE && !ctrl_q[`BIT_MED_EN] |=>
    !(req_q.valid && req_q.level == LVL_MED))
    else $error("medium request passed while disabled");
  a_lo_gate: assert property (CE && !ctrl_q[`BIT_LO_EN] |=>
    !(req_q.valid && req_q.level == LVL_LO))
    else $error("low request passed while disabled");
  a_lo_off_delay: assert property (s_lo_off ##1 CE |=>
    !(req_q.valid && req_q.level == LVL_LO))
    else $error("low still served after enable cleared");
  a_preempt: assert property (req_q.valid && !req_q.is_nmi |->
    !ex_q.nmi && !ex_q.hi)
    else $error("request offered below running level");
  a_nmi_flag: assert property (CE && take && req_q.is_nmi |=>
    ex_q.nmi)
    else $error("nmi flag not set after nmi take");
  // a return while the nmi handler runs ends that handler first
  a_nmi_clear: assert property (CE && CORE_RETURN && ex_q.nmi |=>
    !ex_q.nmi)
    else $error("nmi flag not cleared on return");
  a_irq_level: assert property (CE |=>
    IRQ == |(evt_q & mask_q))
    else $error("interrupt line out of step with status");

endmodule

// ==== core_model.sv ====
/*
  processor core model: takes the controller's request after a set
  delay and pulses handler return when the bench asks for one.
  assumes the controller's CLK and RST, and lic_pkg compiled first.
*/
`timescale 1ns/100ps
module core_model import lic_pkg::*; (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire core_req_t  REQ,
  input  wire logic [7:0] DELAY,
  input  wire logic       RET_CMD,
  output logic            ACK,
  output logic            RET
);
  logic [7:0] wait_q; // cycles the request has stood
  logic [7:0] wait_d;
  logic       ack_d;
  logic       ret_d;

  // slow answers model a core busy on a long instruction
  // acknowledge strobe, return pulse
  always_comb begin
    wait_d = REQ.valid ? wait_q + 8'h01 : 8'h00;
    ack_d  = REQ.valid && !ACK && (wait_q >= DELAY);
    ret_d  = RET_CMD;
  end

  // registers only; one-cycle pulses
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wait_q <= 8'h00;
      ACK    <= 1'b0;
      RET    <= 1'b0;
    end else begin
      wait_q <= wait_d;
      ACK    <= ack_d;
      RET    <= ret_d;
    end
  end
endmodule

// ==== testbench.sv ====
/*
  self-checking bench for the interrupt controller: avalon register
  tasks, a core model as far side, one task per scenario.
  assumes lic_pkg and lic_consts.svh from the design.
*/
`timescale 1ns/100ps
`include "lic_consts.svh"
module testbench import lic_pkg::*;;
  logic        clk, rst, rd_s, wr_s, nmi, ack, ret, ret_cmd;
  logic        sel, irq, waitreq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, level;
  logic [31:0] rd_got;        // read data taken at the answer edge
  logic [15:0] pend;          // per-source request lines
  logic [7:0]  delay;         // core answer delay
  core_req_t   req;
  int          miscompares, samples_checked, cycles;

  level_interrupt_controller DUT (.CLK(clk), .RST(rst), .CE(1'b1),
    .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .SRC_PEND(pend), .SRC_LEVEL(level), .NMI_PEND(nmi),
    .CORE_REQ(req), .CORE_ACK(ack), .CORE_RETURN(ret),
    .VECTOR_TABLE_SEL(sel), .IRQ(irq));
  core_model core (.CLK(clk), .RST(rst), .REQ(req), .DELAY(delay),
    .RET_CMD(ret_cmd), .ACK(ack), .RET(ret));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, well above the whole run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one bus access, held until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [2:0] i,
                     input logic [7:0] d);
    @(posedge clk);
    addr  <= {i, 2'b00};
    wdata <= {24'h000000, d};
    rd_s  <= !w;
    wr_s  <= w;
    // no cycle count assumed; the hang guard ends a stuck wait
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rd_got = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rdc(input logic [2:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(rd_got, {24'h000000, e});
  endtask

  // raise the masked sources at one edge with one level
  task automatic raise(input logic [15:0] m, input logic [1:0] l);
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      if (m[i]) level[2*i +: 2] <= l;
    end
    pend <= pend | m;
  endtask

  // wait for the core to take a request; drop the serviced line
  task automatic serve(input logic [7:0] v, input logic [1:0] l);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    chk({21'h0, ack, req.level, req.vector}, {21'h0, 1'b1, l, v});
    @(posedge clk);
    if (v == `NMI_VECTOR) nmi <= 1'b0;
    else pend[v[3:0]] <= 1'b0;
  endtask

  task automatic hret();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    rdc(`IDX_EXEC, 8'h00);
    rdc(`IDX_PTR, 8'h00);
    rdc(`IDX_CTRL, 8'h00);
    rdc(3'h6, 8'h00);
    wr(`IDX_CTRL, 8'hFF);
    rdc(`IDX_CTRL, 8'h87);
    chk({31'h0, sel}, 32'h0);
    $display("test reset_and_control done");
  endtask

  task automatic t_static();
    wr(`IDX_CTRL, 8'h07);
    raise(16'h0024, LVL_LO);
    serve(8'h02, LVL_LO);
    rdc(`IDX_EXEC, 8'h01);
    raise(16'h0200, LVL_MED);
    serve(8'h09, LVL_MED);
    rdc(`IDX_EXEC, 8'h03);
    hret();
    rdc(`IDX_EXEC, 8'h01);
    hret();
    serve(8'h05, LVL_LO);
    hret();
    rdc(`IDX_EXEC, 8'h00);
    $display("test static_nesting done");
  endtask

  task automatic t_nmi();
    raise(16'h0001, LVL_LO);
    serve(8'h00, LVL_LO);
    @(posedge clk);
    nmi <= 1'b1;
    serve(`NMI_VECTOR, LVL_HI);
    rdc(`IDX_EXEC, 8'h81);
    hret();
    rdc(`IDX_EXEC, 8'h01);
    hret();
    rdc(`IDX_EXEC, 8'h00);
    $display("test nmi done");
  endtask

  task automatic t_rr();
    wr(`IDX_CTRL, 8'h81);
    raise(16'h0012, LVL_LO);
    serve(8'h01, LVL_LO);
    rdc(`IDX_PTR, 8'h01);
    raise(16'h0002, LVL_LO);
    hret();
    serve(8'h04, LVL_LO);
    rdc(`IDX_PTR, 8'h04);
    hret();
    serve(8'h01, LVL_LO);
    hret();
    wr(`IDX_PTR, 8'h06);
    raise(16'h0088, LVL_LO);
    serve(8'h07, LVL_LO);
    hret();
    serve(8'h03, LVL_LO);
    hret();
    // turning rotation off keeps the pointer
    wr(`IDX_CTRL, 8'h01);
    rdc(`IDX_PTR, 8'h03);
    wr(`IDX_CTRL, 8'h83);
    wr(`IDX_PTR, 8'h00);
    raise(16'h0005, LVL_MED);
    serve(8'h00, LVL_MED);
    rdc(`IDX_PTR, 8'h00);
    hret();
    serve(8'h02, LVL_MED);
    hret();
    $display("test round_robin done");
  endtask

  task automatic t_enable();
    for (int l = 1; l < 4; l++) begin
      wr(`IDX_CTRL, 8'h07 ^ (8'h01 << (l - 1)));
      raise(16'h0040, l[1:0]);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({31'h0, req.valid}, 32'h0);
      wr(`IDX_CTRL, 8'h07);
      serve(8'h06, l[1:0]);
      hret();
    end
    // slow core: request stands while the enable is cleared
    delay <= 8'h28;
    raise(16'h0008, LVL_LO);
    while (req.valid !== 1'b1) @(negedge clk);
    wr(`IDX_CTRL, 8'h06);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({31'h0, req.valid}, 32'h0);
    pend  <= 16'h0000;
    delay <= 8'h01;
    $display("test level_enables done");
  endtask

  task automatic t_irq();
    bus(1'b0, `IDX_EVT, 8'h00);
    wr(`IDX_MASK, 8'h04);
    hret();
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, `IDX_EVT, 8'h00);
    chk(rd_got & 32'h4, 32'h4);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`IDX_MASK, 8'h00);
    hret();
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt_line done");
  endtask

  task automatic t_vsel();
    wr(`IDX_CTRL, 8'h40);
    @(negedge clk);
    chk({31'h0, sel}, 32'h0);
    wr(`IDX_UNLOCK, `UNLOCK_KEY);
    wr(`IDX_CTRL, 8'h40);
    @(negedge clk);
    chk({31'h0, sel}, 32'h1);
    rdc(`IDX_CTRL, 8'h40);
    $display("test vector_select done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // reset for 20 cycles, then every scenario in turn
  initial begin
    rst = 1'b1;
    rd_s = 1'b0;
    wr_s = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    pend = 16'h0000;
    level = 32'h0;
    nmi = 1'b0;
    ret_cmd = 1'b0;
    delay = 8'h01;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_static();
    t_nmi();
    t_rr();
    t_enable();
    t_irq();
    t_vsel();
    complete_run();
  end
endmodule
